// [core/shr_defs.svh]
// Constants for the shadow RAM and cache control register bank.
// Assumes an 8-bit register port and a 20-bit real-mode memory address.
`ifndef SHR_DEFS_SVH
`define SHR_DEFS_SVH

// ==========================================================
// Register offsets and reset values
`define SHR_ROM_CTL_ADDR      8'h26
`define SHR_CACHE_CTL_ADDR    8'h40
`define SHR_ROM_CTL_RST       8'h10
`define SHR_CACHE_CTL_RST     8'hdf

// ==========================================================
// Field positions of shadow_rom_control
`define SHR_ROM_WR_CS_BIT     7
`define SHR_COPY_EN_BIT       6
`define SHR_WPROT_BIT         5
`define SHR_SMM_BURST_BIT     4
`define SHR_SEG_EN_MSB        3
`define SHR_SEG_EN_LSB        0

// ==========================================================
// Field positions of cache_and_at_cycle_control
`define SHR_CACHE_DIS_BIT     7
`define SHR_FAST_AT_BIT       6
`define SHR_B2B_IO_BIT        5

// ==========================================================
// Address nibbles of the 64KB pages that are decoded
`define SHR_PAGE_C            4'hc
`define SHR_PAGE_E            4'he
`define SHR_PAGE_A            4'ha
`define SHR_ROM_PAGE_LO       4'he

// ==========================================================
// Timing in isa_bus_clock periods
`define SHR_BALE_DLY_NORM     2'h2
`define SHR_BALE_DLY_FAST     2'h1
`define SHR_B2B_IO_GAP        2'h3

`endif

// [core/shr_pkg.sv]
// Types of the shadow RAM and cache control register bank.
// Assumes shr_defs.svh is on the include path.
`include "shr_defs.svh"

package shr_pkg;

	// ==========================================================
	// ISA cycle sequencer
	typedef enum logic [2:0]
	{
		SHR_IDLE,
		SHR_DLY,
		SHR_BALE,
		SHR_BUSY,
		SHR_GAP
	} shr_isa_e;

	// ==========================================================
	// Whole state of the block
	typedef struct packed
	{
		logic [7:0] rom_ctl;
		logic [7:0] cache_ctl;
		logic [7:0] rdata;
		logic       at_s1;
		logic       at_s2;
		logic       at_s3;
		logic       at_filt;
		shr_isa_e   st;
		logic [1:0] cnt;
		logic       cur_rom;
		logic       pend;
		logic       pend_io;
		logic       pend_rom;
		logic       cur_io;
		logic       route_valid;
		logic       dram_sel;
		logic       dram_we;
		logic       isa_sel;
		logic       rom_cs_n;
		logic       bale;
		logic       nonburst;
		logic       l1_en;
		logic       l2_en;
		logic       isa_busy;
	} shr_state_s;

	localparam shr_state_s SHR_RESET = '{
		rom_ctl:   `SHR_ROM_CTL_RST,
		cache_ctl: `SHR_CACHE_CTL_RST,
		st:        SHR_IDLE,
		rom_cs_n:  1'b1,
		default:   '0
	};

endpackage

// [core/shr_ctrl.sv]
// Shadow RAM, ROM chip select, SYSTEM_MANAGEMENT_MODE burst, cache and ISA cycle start control.
// Assumes a CPU cycle decoder that pulses cyc_start with the cycle's
// attributes, and ISA cycle logic on mclk that pulses isa_done.
`timescale 1ns/1ps
`include "shr_defs.svh"

module shr_ctrl
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        cyc_start,
	input  wire logic [19:0] cyc_addr,
	input  wire logic        cyc_write,
	input  wire logic        cyc_io,
	input  wire logic        system_management_mode,
	input  wire logic [3:0]  seg_companion_en,
	input  wire logic        isa_bus_clock,
	input  wire logic        isa_done,
	output logic             route_valid,
	output logic             dram_sel,
	output logic             dram_we,
	output logic             isa_sel,
	output logic             rom_chip_select_n,
	output logic             bale,
	output logic             nonburst_rdy,
	output logic             l1_cache_en,
	output logic             l2_cache_en,
	output logic             isa_busy
);

	// ==========================================================
	// Decode helpers

	// The segment index is simply address bits 15:14, so bit 0 of the
	// enable field covers the lowest 16KB.
	function automatic logic seg_hit(input logic [19:0] a, input logic [3:0] en,
		input logic [3:0] comp);
		seg_hit = (a[19:16] == `SHR_PAGE_C) && en[a[15:14]] && comp[a[15:14]];
	endfunction

	function automatic logic in_copy_area(input logic [19:0] a);
		in_copy_area = (a[19:16] >= `SHR_PAGE_C) && (a[19:16] <= `SHR_PAGE_E);
	endfunction

	// Both the write and the read path decode the same register offsets.
	function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] offs);
		reg_hit = (a == offs);
	endfunction

	shr_pkg::shr_state_s s_ff;
	shr_pkg::shr_state_s nxt_s;

	logic       at_rise;
	logic       mem_isa;
	logic       rom_space;
	logic       go_isa;
	logic       go_rom;
	logic [1:0] bale_dly;

	// ==========================================================
	// Next state
	always_comb
	begin
		nxt_s = s_ff;

		// ==========================================================
		// ISA clock synchroniser
		// The ISA clock is foreign; a change counts only once the second
		// and third stages agree, which filters a metastable first stage.
		nxt_s.at_s1 = isa_bus_clock;
		nxt_s.at_s2 = s_ff.at_s1;
		nxt_s.at_s3 = s_ff.at_s2;
		if (s_ff.at_s2 == s_ff.at_s3)
		begin
			nxt_s.at_filt = s_ff.at_s3;
		end
		at_rise = (s_ff.at_s2 == s_ff.at_s3) && s_ff.at_s3 && !s_ff.at_filt;

		// ==========================================================
		// Register port
		// Read data stand for one cycle only, so a later read never
		// sees a stale value.
		if (reg_wr && reg_hit(reg_addr, `SHR_ROM_CTL_ADDR))
		begin
			nxt_s.rom_ctl = reg_wdata;
		end
		if (reg_wr && reg_hit(reg_addr, `SHR_CACHE_CTL_ADDR))
		begin
			nxt_s.cache_ctl = reg_wdata;
		end
		nxt_s.rdata = 8'h00;
		if (reg_rd && reg_hit(reg_addr, `SHR_ROM_CTL_ADDR))
		begin
			nxt_s.rdata = s_ff.rom_ctl;
		end
		if (reg_rd && reg_hit(reg_addr, `SHR_CACHE_CTL_ADDR))
		begin
			nxt_s.rdata = s_ff.cache_ctl;
		end

		// ==========================================================
		// Cache enables
		// Both levels follow one bit; software cannot enable only one of them.
		nxt_s.l1_en = !s_ff.cache_ctl[`SHR_CACHE_DIS_BIT];
		nxt_s.l2_en = !s_ff.cache_ctl[`SHR_CACHE_DIS_BIT];

		// ==========================================================
		// Memory routing, decided once per CPU cycle
		// Companion enables are a level from another bank; a change between
		// cycles only affects the next cycle.
		mem_isa   = 1'b0;
		rom_space = (cyc_addr[19:16] >= `SHR_ROM_PAGE_LO);
		go_isa    = 1'b0;
		go_rom    = 1'b0;
		nxt_s.route_valid = 1'b0;
		if (cyc_start)
		begin
			nxt_s.route_valid = 1'b1;
			nxt_s.dram_sel = 1'b0;
			nxt_s.dram_we  = 1'b0;
			nxt_s.isa_sel  = 1'b0;
			if (cyc_io)
			begin
				go_isa = 1'b1;
			end
			else if (s_ff.rom_ctl[`SHR_COPY_EN_BIT] && in_copy_area(cyc_addr))
			begin
				nxt_s.dram_sel = cyc_write;
				nxt_s.dram_we  = cyc_write;
				mem_isa        = !cyc_write;
			end
			else if (seg_hit(cyc_addr, s_ff.rom_ctl[`SHR_SEG_EN_MSB:`SHR_SEG_EN_LSB],
				seg_companion_en))
			begin
				nxt_s.dram_sel = 1'b1;
				nxt_s.dram_we  = cyc_write && !s_ff.rom_ctl[`SHR_WPROT_BIT];
			end
			else if (cyc_addr[19:16] < `SHR_PAGE_A)
			begin
				nxt_s.dram_sel = 1'b1;
				nxt_s.dram_we  = cyc_write;
			end
			else
			begin
				mem_isa = 1'b1;
			end
			if (mem_isa)
			begin
				go_isa = 1'b1;
				go_rom = rom_space && (!cyc_write || s_ff.rom_ctl[`SHR_ROM_WR_CS_BIT]);
			end
			nxt_s.isa_sel  = go_isa;
			nxt_s.nonburst = system_management_mode && !cyc_io
				&& !s_ff.rom_ctl[`SHR_SMM_BURST_BIT];
		end

		// ==========================================================
		// ISA cycle start sequencer
		bale_dly = s_ff.cache_ctl[`SHR_FAST_AT_BIT] ? `SHR_BALE_DLY_FAST
			: `SHR_BALE_DLY_NORM;
		if (go_isa && s_ff.st != shr_pkg::SHR_IDLE)
		begin
			// A request that finds the sequencer busy is parked here and
			// started as soon as the running cycle or its recovery gap ends.
			nxt_s.pend     = 1'b1;
			nxt_s.pend_io  = cyc_io;
			nxt_s.pend_rom = go_rom;
		end
		nxt_s.bale = 1'b0;
		unique case (s_ff.st)
			shr_pkg::SHR_IDLE:
			begin
				if (go_isa)
				begin
					nxt_s.st      = shr_pkg::SHR_DLY;
					nxt_s.cnt     = bale_dly;
					nxt_s.cur_io  = cyc_io;
					nxt_s.cur_rom = go_rom;
				end
			end
			shr_pkg::SHR_DLY:
			begin
				if (at_rise)
				begin
					nxt_s.cnt = s_ff.cnt - 2'h1;
					if (s_ff.cnt == 2'h1)
					begin
						nxt_s.st   = shr_pkg::SHR_BALE;
						nxt_s.bale = 1'b1;
					end
				end
			end
			shr_pkg::SHR_BALE:
			begin
				nxt_s.bale = !at_rise;
				if (at_rise)
				begin
					nxt_s.st = shr_pkg::SHR_BUSY;
				end
			end
			shr_pkg::SHR_BUSY:
			begin
				if (isa_done)
				begin
					if (s_ff.cur_io && !s_ff.cache_ctl[`SHR_B2B_IO_BIT])
					begin
						nxt_s.st  = shr_pkg::SHR_GAP;
						nxt_s.cnt = `SHR_B2B_IO_GAP;
					end
					else if (nxt_s.pend)
					begin
						// A parked request starts straight from the finished cycle
						// unless a recovery gap follows an I/O cycle; then it stays
						// parked and is started at the gap's end.
						nxt_s.st      = shr_pkg::SHR_DLY;
						nxt_s.cnt     = bale_dly;
						nxt_s.cur_io  = nxt_s.pend_io;
						nxt_s.cur_rom = nxt_s.pend_rom;
						nxt_s.pend    = 1'b0;
					end
					else
					begin
						nxt_s.st = shr_pkg::SHR_IDLE;
					end
				end
			end
			shr_pkg::SHR_GAP:
			begin
				// The gap is only needed before a following I/O cycle; a memory
				// cycle waiting here is released at the gap's end as well,
				// which costs a little time but keeps one sequencer.
				if (at_rise)
				begin
					nxt_s.cnt = s_ff.cnt - 2'h1;
					if (s_ff.cnt == 2'h1)
					begin
						nxt_s.st = shr_pkg::SHR_IDLE;
						if (nxt_s.pend)
						begin
							nxt_s.st      = shr_pkg::SHR_DLY;
							nxt_s.cnt     = bale_dly;
							nxt_s.cur_io  = nxt_s.pend_io;
							nxt_s.cur_rom = nxt_s.pend_rom;
							nxt_s.pend    = 1'b0;
						end
					end
				end
			end
			default:
			begin
				nxt_s.st = shr_pkg::SHR_IDLE;
			end
		endcase

		nxt_s.isa_busy = (nxt_s.st != shr_pkg::SHR_IDLE);
		nxt_s.rom_cs_n = !(nxt_s.cur_rom && (nxt_s.st == shr_pkg::SHR_DLY
			|| nxt_s.st == shr_pkg::SHR_BALE || nxt_s.st == shr_pkg::SHR_BUSY));
	end

	// ==========================================================
	// State register
	// One register holds the whole state, so reset loads a single constant.
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s_ff <= shr_pkg::SHR_RESET;
		end
		else
		begin
			s_ff <= nxt_s;
		end
	end

	// ==========================================================
	// Outputs
	assign reg_rdata         = s_ff.rdata;
	assign route_valid       = s_ff.route_valid;
	assign dram_sel          = s_ff.dram_sel;
	assign dram_we           = s_ff.dram_we;
	assign isa_sel           = s_ff.isa_sel;
	assign rom_chip_select_n = s_ff.rom_cs_n;
	assign bale              = s_ff.bale;
	assign nonburst_rdy      = s_ff.nonburst;
	assign l1_cache_en       = s_ff.l1_en;
	assign l2_cache_en       = s_ff.l2_en;
	assign isa_busy          = s_ff.isa_busy;

endmodule // shr_ctrl

// [verification/shr_ctrl_chk.sv]
// Assertions on the ports of shr_ctrl.
// Assumes a bind from the bench; registers change only through the port.
`timescale 1ns/1ps
module shr_ctrl_chk
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        cyc_start,
	input wire logic [19:0] cyc_addr,
	input wire logic        cyc_write,
	input wire logic        cyc_io,
	input wire logic        system_management_mode,
	input wire logic [3:0]  seg_companion_en,
	input wire logic        isa_done,
	input wire logic        dram_sel,
	input wire logic        dram_we,
	input wire logic        isa_sel,
	input wire logic        rom_chip_select_n,
	input wire logic        bale,
	input wire logic        nonburst_rdy,
	input wire logic        l1_cache_en,
	input wire logic        l2_cache_en,
	input wire logic        isa_busy
);
	// ==========================================
	// Register mirror, so checks never lean on the design's own copy.
	logic [7:0] rom_q;
	logic [7:0] cac_q;
	logic       io_q;
	wire logic [7:0] rexp = (reg_addr == 8'h26) ? rom_q : (reg_addr == 8'h40) ? cac_q : 8'h00;
	wire logic       hit = rom_q[cyc_addr[15:14]] & seg_companion_en[cyc_addr[15:14]];
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rom_q <= 8'h10;
			cac_q <= 8'hdf;
			io_q <= 1'b0;
		end
		else
		begin
			if (reg_wr && reg_addr == 8'h26) rom_q <= reg_wdata;
			if (reg_wr && reg_addr == 8'h40) cac_q <= reg_wdata;
			if (cyc_start) io_q <= cyc_io;
		end
	end
	// ==========================================
	// Properties.
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	sequence isa_go;
		cyc_start && cyc_io && !isa_busy;
	endsequence
	a_reg_read: assert property (
		reg_rd |=> reg_rdata == $past(rexp)) else $error("bad read data");
	a_rom_cs_off: assert property (
		cyc_start && cyc_write && !cyc_io && !isa_busy && cyc_addr[19:17] == 3'h7 && !rom_q[7]
		|=> rom_chip_select_n[*8]) else $error("rom select on write");
	a_copy_route: assert property (
		cyc_start && !cyc_io && rom_q[6] && cyc_addr[19:16] inside {4'hc, 4'hd, 4'he}
		|=> dram_we == $past(cyc_write) && isa_sel != $past(cyc_write)) else $error("bad copy");
	a_smm_burst: assert property (
		cyc_start && !cyc_io && system_management_mode |=> nonburst_rdy != $past(rom_q[4]))
		else $error("bad burst");
	a_seg_map: assert property (
		cyc_start && !cyc_io && !rom_q[6] && cyc_addr[19:16] == 4'hc |=> dram_sel == $past(hit))
		else $error("bad segment");
	a_cache_both: assert property (
		reg_wr && reg_addr == 8'h40 |-> ##2 l1_cache_en == !cac_q[7] && l2_cache_en == !cac_q[7])
		else $error("bad cache enable");
	a_bale_fast: assert property (
		isa_go ##0 cac_q[6] |=> ##[0:18] bale) else $error("late fast bale");
	a_bale_norm: assert property (
		isa_go ##0 !cac_q[6] |=> !bale[*8]) else $error("early bale");
	a_io_gap: assert property (
		isa_done && io_q |-> ##2 isa_busy != cac_q[5]) else $error("bad io gap");
endmodule // shr_ctrl_chk

// [verification/shr_isa_model.sv]
// ISA side model: free running bus clock and end-of-cycle pulses.
// Assumes bale from the design; slow stretches the cycle.
`timescale 1ns/1ps
module shr_isa_model
(
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic bale,
	input  wire logic slow,
	output logic      isa_bus_clock,
	output logic      isa_done
);
	logic       bale_q;
	logic [3:0] wait_cnt;
	// The odd half period keeps the two clocks drifting in phase.
	initial
	begin
		isa_bus_clock = 1'b0;
		forever #50.3 isa_bus_clock = ~isa_bus_clock;
	end
	always_ff @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			bale_q <= 1'b0;
			wait_cnt <= 4'h0;
			isa_done <= 1'b0;
		end
		else
		begin
			bale_q <= bale;
			isa_done <= (wait_cnt == 4'h1);
			if (bale_q && !bale) wait_cnt <= slow ? 4'h9 : 4'h1;
			else if (wait_cnt != 4'h0) wait_cnt <= wait_cnt - 4'h1;
		end
	end
endmodule // shr_isa_model

// [verification/testbench.sv]
// Self-checking bench for shr_ctrl.
// Assumes the checker and the ISA model are compiled first.
`timescale 1ns/1ps
module testbench;
	logic        mclk, rst, reg_wr, reg_rd, cyc_start, cyc_write, cyc_io, slow;
	logic        system_management_mode, isa_bus_clock, isa_done, route_valid, dram_sel;
	logic        dram_we, isa_sel, rom_chip_select_n, bale, nonburst_rdy;
	logic        l1_cache_en, l2_cache_en, isa_busy;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, rom, cac;
	logic [19:0] cyc_addr;
	logic [3:0]  seg_companion_en;
	int          errors, cmp_count, cycles;

	shr_ctrl dut_u (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .cyc_start,
		.cyc_addr, .cyc_write, .cyc_io, .system_management_mode, .seg_companion_en, .isa_bus_clock,
		.isa_done, .route_valid, .dram_sel, .dram_we, .isa_sel, .rom_chip_select_n, .bale,
		.nonburst_rdy, .l1_cache_en, .l2_cache_en, .isa_busy);
	shr_isa_model isa_u (.mclk, .rst, .bale, .slow, .isa_bus_clock, .isa_done);

	// ==========================================
	// Checking and bus tasks; wr, rd and cpu are entered in the time step of a rising edge.
	task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		chk("reg_rdata", reg_rdata, exp);
		@(posedge mclk);
	endtask
	// Returns dram_sel, dram_we and isa_sel.
	function automatic logic [2:0] route(input logic [19:0] a, input logic w, input logic io);
		logic [1:0] s;
		s = a[15:14];
		if (io) return 3'b001;
		if (rom[6] && a[19:16] >= 4'hc && a[19:16] <= 4'he) return w ? 3'b110 : 3'b001;
		if (a[19:16] == 4'hc && rom[s] && seg_companion_en[s]) return {1'b1, w & ~rom[5], 1'b0};
		if (a[19:16] < 4'ha) return {1'b1, w, 1'b0};
		return 3'b001;
	endfunction
	task automatic cpu(input logic [19:0] a, input logic w, input logic io);
		logic [3:0] e;
		logic       cs;
		int         g;
		e = {1'b1, route(a, w, io)};
		cs = 1'b0;
		g = 0;
		cyc_addr <= a;
		cyc_write <= w;
		cyc_io <= io;
		cyc_start <= 1'b1;
		@(posedge mclk);
		cyc_start <= 1'b0;
		#1;
		chk("route", {route_valid, dram_sel, dram_we, isa_sel}, e);
		if (!io)
			chk("nonburst_rdy", nonburst_rdy, system_management_mode & ~rom[4]);
		while (isa_busy)
		begin
			cs |= ~rom_chip_select_n;
			if (isa_done || g > 0) g++;
			@(posedge mclk);
			#1;
		end
		if (e[0])
		begin
			chk("rom_cs", cs, !io && a[19:17] == 3'h7 && (!w || rom[7]));
			chk("io_gap", g > 12, io && !cac[5]);
		end
		@(posedge mclk);
	endtask

	// ==========================================
	// Clock, timeout and main sequence.
	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			errors++;
			final_report;
		end
	end
	initial
	begin
		{rst, reg_wr, reg_rd, cyc_start, cyc_write, cyc_io, slow} = 7'h41;
		{system_management_mode, reg_addr, reg_wdata, cyc_addr, seg_companion_en} = '0;
		rom = 8'h10;
		cac = 8'hdf;
		void'($urandom(77211));
		repeat (12) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		rd(8'h26, 8'h10);
		rd(8'h40, 8'hdf);
		chk("cache_en", {l1_cache_en, l2_cache_en}, 8'h00);
		cpu(20'hf0000, 1'b1, 1'b0);
		cpu(20'he0000, 1'b0, 1'b0);
		repeat (40)
		begin
			rom = 8'($urandom);
			cac = 8'($urandom);
			seg_companion_en <= 4'($urandom);
			system_management_mode <= 1'($urandom);
			slow <= 1'($urandom);
			wr(8'h26, rom);
			wr(8'h40, cac);
			wr(8'h80 | 8'($urandom), 8'hff);
			rd(8'h26, rom);
			rd(8'h40, cac);
			rd(8'h80 | 8'($urandom), 8'h00);
			chk("cache_en", {l1_cache_en, l2_cache_en}, {6'h0, ~cac[7], ~cac[7]});
			cpu({4'($urandom_range(8, 15)), 16'($urandom)}, 1'($urandom), 1'b0);
			cpu(20'($urandom), 1'($urandom), 1'b1);
		end
		// ==========================================
		// Corner: a second I/O cycle issued inside the first one's recovery gap.
		cac = 8'h00;
		wr(8'h40, cac);
		slow <= 1'b0;
		cyc_addr <= 20'h00300;
		cyc_write <= 1'b0;
		cyc_io <= 1'b1;
		cyc_start <= 1'b1;
		@(posedge mclk);
		cyc_start <= 1'b0;
		#1;
		while (!isa_done)
		begin
			@(posedge mclk);
			#1;
		end
		@(posedge mclk);
		cpu(20'h00304, 1'b1, 1'b1);
		// ==========================================
		// Corner: a reset in mid-run restores the defaults.
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		rom = 8'h10;
		cac = 8'hdf;
		@(posedge mclk);
		rd(8'h26, rom);
		rd(8'h40, cac);
		chk("cache_en", {l1_cache_en, l2_cache_en}, 8'h00);
		final_report;
	end
endmodule // testbench

bind shr_ctrl shr_ctrl_chk chk_u (.mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
	.reg_rdata, .cyc_start, .cyc_addr, .cyc_write, .cyc_io, .system_management_mode,
	.seg_companion_en, .isa_done, .dram_sel, .dram_we, .isa_sel, .rom_chip_select_n, .bale,
	.nonburst_rdy, .l1_cache_en, .l2_cache_en, .isa_busy);
